// [common/alert_mask_pkg.sv]
package alert_mask_pkg;

  // ****************************************
  // command and selector codes
  // ****************************************
  localparam logic [7:0] mask_command_code = 8'h1b;   // shared mask command
  localparam logic [7:0] sel_output_voltage = 8'h7a;  // output voltage class
  localparam logic [7:0] sel_output_current = 8'h7b;  // output current class
  localparam logic [7:0] sel_input = 8'h7c;           // input class
  localparam logic [7:0] sel_temperature = 8'h7d;     // temperature class
  localparam logic [7:0] sel_comm_logic = 8'h7e;      // comm/memory/logic class
  localparam logic [7:0] sel_misc = 8'h7f;            // other class
  localparam logic [7:0] phase_all = 8'hff;           // only supported phase

  // ****************************************
  // writable bit layouts per class
  // ****************************************
  localparam logic [7:0] wmask_output_voltage = 8'hfc;  // bits 7:2
  localparam logic [7:0] wmask_output_current = 8'hb0;  // bits 7,5,4
  localparam logic [7:0] wmask_input = 8'he8;           // bits 7,6,5,3
  localparam logic [7:0] wmask_temperature = 8'hc0;     // bits 7,6
  localparam logic [7:0] wmask_comm_logic = 8'hfa;      // bits 7..3,1
  localparam logic [7:0] wmask_misc = 8'h00;            // nothing writable
  localparam logic [7:0] fixed_misc = 8'h01;            // initial alert flag masked
  localparam logic [7:0] input_reset_clear = 8'he0;     // input bits that reset to 0

  // ****************************************
  // reset and access timing
  // ****************************************
  localparam logic [7:0] mask_reset_zero = 8'h00;  // value before nvm load
  localparam int read_latency_cycles = 1;          // read answer one cycle after request

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;          // one-cycle request strobe
    logic write;          // 1 write word, 0 process-call read
    logic [7:0] command;  // command code
    logic [7:0] phase;    // current phase selection
    logic [7:0] selector; // status class selector (low byte)
    logic [7:0] data;     // new mask (high byte)
  } mask_request_type;

  typedef struct packed {
    logic valid;      // one-cycle answer strobe
    logic error;      // request not accepted
    logic [7:0] data; // mask byte on reads
  } mask_answer_type;

  typedef struct packed {
    logic [7:0] output_voltage;
    logic [7:0] output_current;
    logic [7:0] input_class;
    logic [7:0] temperature;
    logic [7:0] comm_logic;
    logic [7:0] misc;
  } status_set_type;

endpackage

// [design/mask_cell.sv]
`timescale 1ns/10ps
// one mask register with fixed and writable bits
module mask_cell #(
  parameter logic [7:0] writable = 8'h00,
  parameter logic [7:0] fixed = 8'h00
) (
  // clock and control
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // nvm load
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  // host write
  input wire logic write_i,
  input wire logic [7:0] write_data_i,
  // value
  output logic [7:0] value_o
);
  import alert_mask_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] bits;  // writable bits only
  } cell_state_type;

  cell_state_type state_q;  // registered state
  cell_state_type state_d;  // next state

  // next-state: load wins over write so nvm values land cleanly
  always_comb begin
    state_d = state_q;
    if (load_i) begin
      state_d.bits = load_data_i & writable;
    end else if (write_i) begin
      state_d.bits = write_data_i & writable;
    end
  end

  // register, frozen while enable is low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= '{bits: mask_reset_zero};
    end else if (enable_i) begin
      state_q <= state_d;
    end
  end

  // fixed bits are forced, so unsupported positions read constant
  assign value_o = state_q.bits | fixed;
endmodule

// [design/alert_gate.sv]
`timescale 1ns/10ps
// combines status and masks into the alert request
module alert_gate (
  // inputs
  input wire logic [7:0] status_i,
  input wire logic [7:0] mask_i,
  // output
  output logic hit_o
);
  // a clear mask bit lets its status bit through
  assign hit_o = |(status_i & ~mask_i);
endmodule

// [design/alert_mask_bank.sv]
`timescale 1ns/10ps
module alert_mask_bank (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // nvm restore
  input wire logic nvm_load_i,
  input wire alert_mask_pkg::status_set_type nvm_masks_i,
  // decoded pmbus request
  input wire alert_mask_pkg::mask_request_type request_i,
  // status bits from the status registers
  input wire alert_mask_pkg::status_set_type status_i,
  // answer and alert
  output alert_mask_pkg::mask_answer_type answer_o,
  output alert_mask_pkg::status_set_type masks_o,
  output logic alert_n_o
);
  import alert_mask_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mask_answer_type answer;  // registered answer
    logic alert;              // registered alert request
    logic load_pending;       // nvm load owed after reset
  } bank_state_type;

  bank_state_type state_q;  // registered state
  bank_state_type state_d;  // next state

  // ****************************************
  // decode
  // ****************************************
  logic accept;         // request for this block with legal phase
  logic [5:0] hit;      // one-hot class select
  logic [5:0] write_en; // per class write strobe
  logic load;           // nvm load strobe
  status_set_type masks;  // current mask values
  logic [5:0] class_hit;  // per class alert term
  logic [7:0] read_data;  // selected mask byte

  // only the shared code and the all-phase selection are served
  assign accept = request_i.valid && (request_i.command == mask_command_code)
                  && (request_i.phase == phase_all);

  // selector from the low byte picks the class
  assign hit[0] = (request_i.selector == sel_output_voltage);
  assign hit[1] = (request_i.selector == sel_output_current);
  assign hit[2] = (request_i.selector == sel_input);
  assign hit[3] = (request_i.selector == sel_temperature);
  assign hit[4] = (request_i.selector == sel_comm_logic);
  assign hit[5] = (request_i.selector == sel_misc);

  // writes land the high byte at once, even while running
  assign write_en = (accept && request_i.write) ? hit : 6'h00;

  // load pulse on the first enabled cycle after reset or on demand
  assign load = state_q.load_pending || nvm_load_i;

  // ****************************************
  // mask registers
  // ****************************************
  // output voltage: bits 7:2 writable
  mask_cell #(.writable(wmask_output_voltage), .fixed(8'h00)) u_vout (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .load_i(load),
    .load_data_i(nvm_masks_i.output_voltage),
    .write_i(write_en[0]),
    .write_data_i(request_i.data),
    .value_o(masks.output_voltage)
  );

  // output current: bits 7,5,4 writable
  mask_cell #(.writable(wmask_output_current), .fixed(8'h00)) u_iout (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .load_i(load),
    .load_data_i(nvm_masks_i.output_current),
    .write_i(write_en[1]),
    .write_data_i(request_i.data),
    .value_o(masks.output_current)
  );

  // input: bits 7:5 reset to zero, bit 3 from nvm
  mask_cell #(.writable(wmask_input), .fixed(8'h00)) u_input (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .load_i(load),
    .load_data_i(nvm_masks_i.input_class & ~input_reset_clear),
    .write_i(write_en[2]),
    .write_data_i(request_i.data),
    .value_o(masks.input_class)
  );

  // temperature: bits 7:6 writable
  mask_cell #(.writable(wmask_temperature), .fixed(8'h00)) u_temp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .load_i(load),
    .load_data_i(nvm_masks_i.temperature),
    .write_i(write_en[3]),
    .write_data_i(request_i.data),
    .value_o(masks.temperature)
  );

  // comm/memory/logic: bits 7..3 and 1 writable
  mask_cell #(.writable(wmask_comm_logic), .fixed(8'h00)) u_cml (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .load_i(load),
    .load_data_i(nvm_masks_i.comm_logic),
    .write_i(write_en[4]),
    .write_data_i(request_i.data),
    .value_o(masks.comm_logic)
  );

  // other class is a constant: first-to-alert never raises the line
  assign masks.misc = fixed_misc | wmask_misc;

  // ****************************************
  // alert gating
  // ****************************************
  // status bits pass in untouched; masks only gate the line
  alert_gate u_g0 (.status_i(status_i.output_voltage), .mask_i(masks.output_voltage),
                   .hit_o(class_hit[0]));
  alert_gate u_g1 (.status_i(status_i.output_current), .mask_i(masks.output_current),
                   .hit_o(class_hit[1]));
  alert_gate u_g2 (.status_i(status_i.input_class), .mask_i(masks.input_class),
                   .hit_o(class_hit[2]));
  alert_gate u_g3 (.status_i(status_i.temperature), .mask_i(masks.temperature),
                   .hit_o(class_hit[3]));
  alert_gate u_g4 (.status_i(status_i.comm_logic), .mask_i(masks.comm_logic),
                   .hit_o(class_hit[4]));
  alert_gate u_g5 (.status_i(status_i.misc), .mask_i(masks.misc),
                   .hit_o(class_hit[5]));

  // ****************************************
  // read mux
  // ****************************************
  // one byte for the selected class, zero for unknown selectors
  always_comb begin
    case (1'b1)
      hit[0]: read_data = masks.output_voltage;
      hit[1]: read_data = masks.output_current;
      hit[2]: read_data = masks.input_class;
      hit[3]: read_data = masks.temperature;
      hit[4]: read_data = masks.comm_logic;
      hit[5]: read_data = masks.misc;
      default: read_data = 8'h00;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    state_d.load_pending = 1'b0;
    // any unmasked status bit in any class raises the alert
    state_d.alert = |class_hit;
    state_d.answer = '0;
    if (request_i.valid && (request_i.command == mask_command_code)) begin
      state_d.answer.valid = 1'b1;
      // wrong phase or unknown selector is refused
      state_d.answer.error = !accept || !(|hit);
      if (accept && !request_i.write) begin
        state_d.answer.data = read_data;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= '{answer: '0, alert: 1'b0, load_pending: 1'b1};
    end else if (enable_i) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign answer_o = state_q.answer;
  assign alert_n_o = !state_q.alert;
  assign masks_o = masks;
endmodule

// [tb/alert_mask_bank_properties.sv]
`timescale 1ns/10ps
// port-level checks of the mask bank
module alert_mask_bank_properties (
  // clock and control
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  // inputs
  input wire logic nvm_load_i,
  input wire alert_mask_pkg::status_set_type nvm_masks_i,
  input wire alert_mask_pkg::mask_request_type request_i,
  input wire alert_mask_pkg::status_set_type status_i,
  // outputs
  input wire alert_mask_pkg::mask_answer_type answer_o,
  input wire alert_mask_pkg::status_set_type masks_o,
  input wire logic alert_n_o
);
  import alert_mask_pkg::*;
  // writable, fixed and nvm-loadable bits of all classes
  localparam status_set_type wm_all = {wmask_output_voltage, wmask_output_current, wmask_input,
    wmask_temperature, wmask_comm_logic, wmask_misc};
  localparam status_set_type fix_all = {40'h0, fixed_misc};
  localparam status_set_type ld_all = {8'hfc, 8'hb0, 8'h08, 8'hc0, 8'hfa, 8'h00};
  logic taken;  // request for this block answered this edge, refused or not
  logic sel_ok;  // selector inside the class range
  logic good_wr;  // write that must land
  assign taken = enable_i && request_i.valid && request_i.command == mask_command_code;
  assign sel_ok = request_i.selector >= sel_output_voltage && request_i.selector <= sel_misc;
  assign good_wr = taken && request_i.write && sel_ok && request_i.phase == phase_all;
  // picks the class byte named by a selector
  function automatic logic [7:0] pick(status_set_type s, logic [7:0] sel);
    return s[8 * (5 - int'(sel - sel_output_voltage)) +: 8];
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_answer_timing: assert property (taken |=> answer_o.valid)
    else $error("answer missing");
  a_no_stray: assert property (!taken |=> !answer_o.valid)
    else $error("stray answer");
  a_refuse_error: assert property (taken && (request_i.phase != phase_all || !sel_ok)
    |=> answer_o.error && answer_o.data == 8'h00) else $error("refusal wrong");
  a_fixed_bits: assert property ((masks_o & ~wm_all) == fix_all)
    else $error("fixed bits wrong");
  a_write_lands: assert property (good_wr && !nvm_load_i && !$past(reset_i) |=>
    pick(masks_o, $past(request_i.selector)) == (($past(request_i.data)
    & pick(wm_all, $past(request_i.selector))) | pick(fix_all, $past(request_i.selector))))
    else $error("write lost");
  a_read_answer: assert property (taken && !request_i.write && sel_ok &&
    request_i.phase == phase_all |=> !answer_o.error &&
    answer_o.data == pick($past(masks_o), $past(request_i.selector))) else $error("read wrong");
  a_masks_hold: assert property (!$past(reset_i) && !nvm_load_i && !good_wr |=>
    $stable(masks_o)) else $error("mask moved");
  a_nvm_load: assert property (enable_i && nvm_load_i |=>
    masks_o == (($past(nvm_masks_i) & ld_all) | fix_all)) else $error("load wrong");
  a_alert_level: assert property (!$past(reset_i) |->
    alert_n_o == !(|($past(status_i) & ~$past(masks_o)))) else $error("alert wrong");
  // main scenarios
  c_write: cover property (good_wr);
  c_error: cover property (answer_o.error);
  c_alert: cover property ($fell(alert_n_o));
endmodule
bind alert_mask_bank alert_mask_bank_properties u_props (.clk_i, .reset_i, .enable_i,
  .nvm_load_i, .nvm_masks_i, .request_i, .status_i, .answer_o, .masks_o, .alert_n_o);

// [tb/host_model.sv]
`timescale 1ns/10ps
// host side: issues decoded mask requests, one per edge
module host_model (
  // clock
  input wire logic clk_i,
  // answer from the bank
  input wire alert_mask_pkg::mask_answer_type answer_i,
  // request to the bank
  output alert_mask_pkg::mask_request_type request_o
);
  import alert_mask_pkg::*;
  logic ans_valid;  // captured answer strobe
  logic ans_error;  // captured error flag
  logic [7:0] ans_data;  // captured read byte
  initial request_o = '0;
  // holds the request over one edge, then takes the answer; called just after an edge
  task automatic access(input logic wr, input logic [7:0] cmd, input logic [7:0] ph,
                        input logic [7:0] sel, input logic [7:0] dat);
    request_o = '{valid: 1'b1, write: wr, command: cmd, phase: ph, selector: sel, data: dat};
    @(posedge clk_i);
    #1;
    ans_valid = answer_i.valid;
    ans_error = answer_i.error;
    ans_data = answer_i.data;
  endtask
  // write word: selector low byte, mask high byte
  task automatic write_mask(input logic [7:0] sel, input logic [7:0] dat);
    access(1'b1, mask_command_code, phase_all, sel, dat);
  endtask
  // process call: selector in, one byte back; data field carries junk
  task automatic read_mask(input logic [7:0] sel);
    access(1'b0, mask_command_code, phase_all, sel, ~sel);
  endtask
  // released fields show a changed pattern, never the last value
  task automatic idle();
    request_o = {1'b0, ~request_o[32:0]};
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
// self-checking bench with a reference model of the masks
module testbench;
  import alert_mask_pkg::*;
  logic clk_i = 0;
  logic reset_i = 1;
  logic enable_i = 1;
  logic nvm_load_i = 0;
  status_set_type nvm_masks_i = '0;
  status_set_type status_i = '0;
  status_set_type masks_o;
  mask_request_type request_i;
  mask_answer_type answer_o;
  logic alert_n_o;
  int error_cnt = 0;
  int n_checks = 0;
  int wm[6] = '{8'hfc, 8'hb0, 8'he8, 8'hc0, 8'hfa, 8'h00};  // writable bits per class
  int m[6];  // reference mask values
  alert_mask_bank u_alert_mask_bank (.clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
    .nvm_load_i(nvm_load_i), .nvm_masks_i(nvm_masks_i), .request_i(request_i),
    .status_i(status_i), .answer_o(answer_o), .masks_o(masks_o), .alert_n_o(alert_n_o));
  host_model u_host_model (.clk_i(clk_i), .answer_i(answer_o), .request_o(request_i));
  // ****************************************
  // reference model
  // ****************************************
  function automatic status_set_type pack_m();
    status_set_type r;
    for (int i = 0; i < 6; i++) r[8 * (5 - i) +: 8] = m[i][7:0];
    return r;
  endfunction
  // nvm image: writable bits, input bits 7:5 cleared, misc fixed
  function automatic void nvm_ref();
    for (int i = 0; i < 6; i++) m[i] = nvm_masks_i[8 * (5 - i) +: 8] & wm[i];
    m[2] = m[2] & 8'h08;
    m[5] = 1;
  endfunction
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    void'($urandom(32'h9273a95e));
    nvm_masks_i = {$urandom, 16'($urandom)};
    repeat (2) @(posedge clk_i);
    #1 reset_i = 0;
    @(posedge clk_i);
    #1 nvm_ref();
    chk(masks_o === pack_m(), "nvm load");
    // every class written and read back to back
    for (int k = 0; k < 60; k++) begin
      u_host_model.write_mask(8'(k % 6 + 8'h7a), 8'($urandom_range(255)));
      m[k % 6] = (request_i.data & wm[k % 6]) | (k % 6 == 5);
      chk(u_host_model.ans_valid === 1'b1 && u_host_model.ans_error === 1'b0, "ack");
      chk(masks_o === pack_m(), "mask after write");
      u_host_model.read_mask(8'(k % 6 + 8'h7a));
      chk(u_host_model.ans_data === 8'(m[k % 6]), "read back");
    end
    // refusals: bad phase, selectors just outside the range
    for (int k = 0; k < 3; k++) begin
      u_host_model.access(1'b1, mask_command_code, k ? 8'hff : 8'($urandom_range(254)),
                          k == 1 ? 8'h79 : (k == 2 ? 8'h80 : 8'h7c), 8'hff);
      chk(u_host_model.ans_error === 1'b1 && u_host_model.ans_data === 8'h00, "refusal");
      chk(masks_o === pack_m(), "refused write");
    end
    u_host_model.access(1'b0, 8'h1c, 8'hff, 8'h7a, 8'h00);
    chk(u_host_model.ans_valid === 1'b0, "foreign command");
    u_host_model.idle();
    // alert against sparse random status, misc flag alone first
    for (int k = 0; k < 200; k++) begin
      status_i = k ? {$urandom, 16'($urandom)} & {$urandom, 16'($urandom)}
                   & {$urandom, 16'($urandom)} & {$urandom, 16'($urandom)} : 48'h1;
      @(posedge clk_i);
      #1 chk(alert_n_o === ~|(status_i & ~pack_m()), "alert");
    end
    // nvm load wins over a write in the same cycle
    nvm_masks_i = {$urandom, 16'($urandom)};
    nvm_load_i = 1;
    u_host_model.write_mask(sel_temperature, 8'h00);
    nvm_load_i = 0;
    u_host_model.idle();
    nvm_ref();
    chk(masks_o === pack_m(), "load priority");
    // reset in mid-run, then reload
    reset_i = 1;
    @(posedge clk_i);
    #1 chk(masks_o === status_set_type'(48'h1) && alert_n_o === 1'b1, "reset values");
    @(posedge clk_i);
    #1 reset_i = 0;
    @(posedge clk_i);
    #1 nvm_ref();
    chk(masks_o === pack_m(), "reload");
    final_report();
  end
endmodule
